// [design/lpc_flash_pkg.sv]
package lpc_flash_pkg;
    // Frame start codes for single-byte firmware memory cycles
    localparam logic [3:0]  START_FW_READ  = 4'hD;
    localparam logic [3:0]  START_FW_WRITE = 4'hE;
    localparam logic [3:0]  MSIZE_BYTE     = 4'h0;
    localparam logic [3:0]  SYNC_READY     = 4'h0;
    localparam logic [3:0]  SYNC_LONG_WAIT = 4'h6;
    localparam logic [3:0]  LAD_IDLE_LEVEL = 4'hF;
    // Last nibble index of the frame fields (7 and 2 nibbles)
    localparam logic [2:0]  ADDR_LAST      = 3'h6;
    localparam logic [2:0]  PAIR_LAST      = 3'h1;
    // Input-register address inside the 28-bit cycle address
    localparam logic [27:0] GPI_REG_ADDR   = 28'hFBC_0100;
    // Array geometry: 512K bytes, 64K blocks, boot block on top
    localparam int          MEM_AW         = 19;
    localparam int          BLOCK_MSB      = 18;
    localparam int          BLOCK_LSB      = 16;
    localparam logic [2:0]  TOP_BLOCK      = 3'h7;
    // Widths of the two input synchroniser groups
    localparam int          SYS_SYNC_W     = 8;
    localparam int          LINK_SYNC_W    = 11;
endpackage

// [design/sync_bus.sv]
`timescale 1ns/1ps
interface sync_bus #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport src (output raw, input clean);
    modport dst (input raw, output clean);
endinterface

// [design/input_sync.sv]
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sync_bus.dst      bus
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic clean_q;
            // Stage one feeds stage two only; the filter looks at 2 and 3
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_q    <= 1'b0;
                    s2_q    <= 1'b0;
                    s3_q    <= 1'b0;
                    clean_q <= 1'b0;
                end
                else
                begin
                    s1_q <= bus.raw[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        clean_q <= s3_q;
                end
            end
            assign bus.clean[i] = clean_q;
        end
    endgenerate
endmodule

// [design/lpc_flash_pin_control.sv]
`timescale 1ns/1ps
// Function
// - Mode strap high enables parallel programmer interface, low enables LPC.
// - Low system reset input resets the device in either mode.
// - In LPC mode the in-system reset acts exactly like system reset.
// - Host reads current general-purpose input levels through a bus register.
// - Low top-boot-lock input refuses programming of the top boot block.
// - Low write-guard input refuses programming of all lower blocks.
// - Frame strobe starts a transfer and also aborts one in progress.
// - LAD carries command, address, write data in and read data out.
// - Bus-side sequencing runs on the host-supplied link clock.
// - Reset during a read deselects and floats the LAD drivers.
// - Reset during program or erase aborts that operation.
module lpc_flash_pin_control (
    input  wire logic                               clock,
    input  wire logic                               resetn,
    input  wire logic                               lclk,
    input  wire logic                               rst_pin_n,
    input  wire logic                               init_pin_n,
    input  wire logic                               parallel_programmer_mode,
    input  wire logic [3:0]                         chip_select_strap,
    input  wire logic [4:0]                         general_input_pins,
    input  wire logic                               top_boot_lock_n,
    input  wire logic                               write_guard_n,
    input  wire logic                               lframe_n,
    input  wire logic [3:0]                         lad_in,
    output logic      [3:0]                         lad_out,
    output logic                                    lad_oe,
    output logic                                    lpc_if_enable,
    output logic                                    parallel_if_enable,
    output logic                                    op_abort,
    output logic                                    mem_req_valid,
    output logic                                    mem_req_write,
    output logic      [lpc_flash_pkg::MEM_AW-1:0]   mem_req_addr,
    output logic      [7:0]                         mem_req_wdata,
    input  wire logic                               mem_req_ready,
    input  wire logic                               mem_rsp_valid,
    input  wire logic [7:0]                         mem_rsp_data,
    output logic                                    write_refused
);
    import lpc_flash_pkg::*;

    typedef enum logic [3:0] {
        L_IDLE, L_IDSEL, L_ADDR, L_MSIZE, L_WDATA,
        L_TAR_IN, L_SYNC, L_RDATA, L_TAR_OUT
    } link_state_e;
    typedef enum logic [1:0] {C_IDLE, C_REQ, C_RSP} core_state_e;

    logic                   mode_q;
    logic [3:0]             id_q;
    logic [1:0]             crel_q;
    logic [1:0]             lrel_q;
    logic                   abort_q;
    // Combined reset: glitches on the pins reset the device, by intent
    wire                    dev_rst_n = resetn & rst_pin_n
                                        & (mode_q | init_pin_n);
    wire                    crst_n = crel_q[1];
    wire                    lrst_n = lrel_q[1];

    // Reset release is synchronised per domain, assertion stays async
    always_ff @(posedge clock or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
            crel_q <= 2'h0;
        else
            crel_q <= {crel_q[0], 1'b1};
    end

    always_ff @(posedge lclk or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
            lrel_q <= 2'h0;
        else
            lrel_q <= {lrel_q[0], 1'b1};
    end

    // Core clock domain
    logic                   req_tgl_q;
    logic                   ack_tgl_q;
    logic                   seen_q;
    logic                   req_write_q;
    logic [MEM_AW-1:0]      req_addr_q;
    logic [7:0]             req_wdata_q;
    logic [7:0]             rsp_q;
    core_state_e            cst_q;
    logic                   valid_q;
    logic                   cwrite_q;
    logic [MEM_AW-1:0]      caddr_q;
    logic [7:0]             cwdata_q;
    logic                   refused_q;

    sync_bus #(.W(SYS_SYNC_W)) sys_bus ();
    assign sys_bus.raw = {req_tgl_q, top_boot_lock_n, write_guard_n,
                          parallel_programmer_mode, chip_select_strap};
    // Straps must keep flowing while reset is low, else mode_q copies zeros
    input_sync #(.W(SYS_SYNC_W)) u_sys_sync (
        .clk   (clock),
        .rst_n (1'b1),
        .bus   (sys_bus)
    );
    wire                    req_s  = sys_bus.clean[7];
    wire                    tbl_s  = sys_bus.clean[6];
    wire                    wg_s   = sys_bus.clean[5];
    wire                    mode_s = sys_bus.clean[4];
    wire [3:0]              id_s   = sys_bus.clean[3:0];

    // Straps follow the pins while crst_n is held low, are cleared by resetn, and freeze at release
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= 1'b0;
            id_q   <= 4'h0;
        end
        else if (!crst_n)
        begin
            mode_q <= mode_s;
            id_q   <= id_s;
        end
    end

    // Program engine sees abort for as long as the device is in reset
    always_ff @(posedge clock or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
            abort_q <= 1'b1;
        else
            abort_q <= ~crel_q[1];
    end

    wire [2:0]              wblock = req_addr_q[BLOCK_MSB:BLOCK_LSB];
    wire                    top_hit = (wblock == TOP_BLOCK);
    wire                    locked = top_hit ? ~tbl_s
                                             : ~wg_s;
    wire                    new_req = (req_s != seen_q);

    always_ff @(posedge clock or negedge crst_n)
    begin
        if (!crst_n)
        begin
            cst_q     <= C_IDLE;
            seen_q    <= 1'b0;
            ack_tgl_q <= 1'b0;
            valid_q   <= 1'b0;
            cwrite_q  <= 1'b0;
            caddr_q   <= '0;
            cwdata_q  <= 8'h00;
            rsp_q     <= 8'h00;
            refused_q <= 1'b0;
        end
        else
        begin
            refused_q <= 1'b0;
            case (cst_q)
                C_IDLE:
                begin
                    if (new_req)
                    begin
                        seen_q <= req_s;
                        if (req_write_q && locked)
                        begin
                            refused_q <= 1'b1;
                            ack_tgl_q <= ~ack_tgl_q;
                        end
                        else
                        begin
                            valid_q  <= 1'b1;
                            cwrite_q <= req_write_q;
                            caddr_q  <= req_addr_q;
                            cwdata_q <= req_wdata_q;
                            cst_q    <= C_REQ;
                        end
                    end
                end
                C_REQ:
                begin
                    if (mem_req_ready)
                    begin
                        valid_q <= 1'b0;
                        if (cwrite_q)
                        begin
                            ack_tgl_q <= ~ack_tgl_q;
                            cst_q     <= C_IDLE;
                        end
                        else
                            cst_q <= C_RSP;
                    end
                end
                C_RSP:
                begin
                    if (mem_rsp_valid)
                    begin
                        rsp_q     <= mem_rsp_data;
                        ack_tgl_q <= ~ack_tgl_q;
                        cst_q     <= C_IDLE;
                    end
                end
                default:
                    cst_q <= C_IDLE;
            endcase
        end
    end

    assign lpc_if_enable      = ~mode_q;
    assign parallel_if_enable = mode_q;
    assign op_abort           = abort_q;
    assign mem_req_valid      = valid_q;
    assign mem_req_write      = cwrite_q;
    assign mem_req_addr       = caddr_q;
    assign mem_req_wdata      = cwdata_q;
    assign write_refused      = refused_q;

    // Link clock domain
    sync_bus #(.W(LINK_SYNC_W)) link_bus ();
    assign link_bus.raw = {ack_tgl_q, mode_q, id_q, general_input_pins};
    input_sync #(.W(LINK_SYNC_W)) u_link_sync (
        .clk   (lclk),
        .rst_n (lrst_n),
        .bus   (link_bus)
    );
    wire                    ack_s   = link_bus.clean[10];
    wire                    lmode_s = link_bus.clean[9];
    wire [3:0]              lid_s   = link_bus.clean[8:5];
    wire [4:0]              gpi_s   = link_bus.clean[4:0];

    link_state_e            lst_q;
    logic [2:0]             cnt_q;
    logic                   write_q;
    logic [27:0]            addr_q;
    logic [7:0]             data_q;
    logic                   issued_q;
    logic [3:0]             lad_q;
    logic                   oe_q;

    wire                    is_gpi   = (addr_q == GPI_REG_ADDR);
    wire                    req_free = (req_tgl_q == ack_s);
    wire                    start_ok = (lad_in == START_FW_READ)
                                       || (lad_in == START_FW_WRITE);
    wire                    done     = is_gpi || (issued_q && req_free);
    wire                    last2    = (cnt_q == PAIR_LAST);

    always_ff @(posedge lclk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            lst_q       <= L_IDLE;
            oe_q        <= 1'b0;
            lad_q       <= LAD_IDLE_LEVEL;
            cnt_q       <= 3'h0;
            write_q     <= 1'b0;
            addr_q      <= 28'h000_0000;
            data_q      <= 8'h00;
            issued_q    <= 1'b0;
            req_tgl_q   <= 1'b0;
            req_write_q <= 1'b0;
            req_addr_q  <= '0;
            req_wdata_q <= 8'h00;
        end
        else if (!lframe_n)
        begin
            // Any frame strobe ends the current cycle at once
            oe_q    <= 1'b0;
            cnt_q   <= 3'h0;
            write_q <= (lad_in == START_FW_WRITE);
            lst_q   <= (start_ok && !lmode_s) ? L_IDSEL : L_IDLE;
        end
        else
        begin
            case (lst_q)
                L_IDSEL:
                    lst_q <= (lad_in == lid_s) ? L_ADDR : L_IDLE;
                L_ADDR:
                begin
                    addr_q <= {addr_q[23:0], lad_in};
                    cnt_q  <= cnt_q + 3'h1;
                    if (cnt_q == ADDR_LAST)
                        lst_q <= L_MSIZE;
                end
                L_MSIZE:
                begin
                    cnt_q <= 3'h0;
                    if (lad_in != MSIZE_BYTE)
                        lst_q <= L_IDLE;
                    else
                        lst_q <= write_q ? L_WDATA : L_TAR_IN;
                end
                L_WDATA:
                begin
                    data_q <= {lad_in, data_q[7:4]};
                    cnt_q  <= last2 ? 3'h0 : cnt_q + 3'h1;
                    if (last2)
                        lst_q <= L_TAR_IN;
                end
                L_TAR_IN:
                begin
                    cnt_q <= last2 ? 3'h0 : cnt_q + 3'h1;
                    if (last2)
                    begin
                        oe_q     <= 1'b1;
                        lad_q    <= SYNC_LONG_WAIT;
                        issued_q <= 1'b0;
                        lst_q    <= L_SYNC;
                    end
                end
                L_SYNC:
                begin
                    // A request left over from an aborted cycle drains first
                    if (!is_gpi && !issued_q && req_free)
                    begin
                        issued_q    <= 1'b1;
                        req_tgl_q   <= ~req_tgl_q;
                        req_write_q <= write_q;
                        req_addr_q  <= addr_q[MEM_AW-1:0];
                        req_wdata_q <= data_q;
                    end
                    if (done)
                    begin
                        lad_q <= SYNC_READY;
                        if (!write_q)
                            data_q <= is_gpi ? {3'h0, gpi_s}
                                             : rsp_q;
                        lst_q <= write_q ? L_TAR_OUT : L_RDATA;
                    end
                end
                L_RDATA:
                begin
                    lad_q  <= data_q[3:0];
                    data_q <= {4'h0, data_q[7:4]};
                    cnt_q  <= last2 ? 3'h0 : cnt_q + 3'h1;
                    if (last2)
                        lst_q <= L_TAR_OUT;
                end
                L_TAR_OUT:
                begin
                    lad_q <= LAD_IDLE_LEVEL;
                    cnt_q <= last2 ? 3'h0 : cnt_q + 3'h1;
                    if (last2)
                    begin
                        oe_q  <= 1'b0;
                        lst_q <= L_IDLE;
                    end
                end
                default:
                    lst_q <= L_IDLE;
            endcase
        end
    end

    assign lad_out = lad_q;
    assign lad_oe  = oe_q;
endmodule

// [sim/lpc_flash_pin_control_sva.sv]
`timescale 1ns/1ps
module lpc_flash_pin_control_sva (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        lclk,
    input wire logic        rst_pin_n,
    input wire logic        init_pin_n,
    input wire logic        parallel_programmer_mode,
    input wire logic        top_boot_lock_n,
    input wire logic        write_guard_n,
    input wire logic        lframe_n,
    input wire logic        lad_oe,
    input wire logic        lpc_if_enable,
    input wire logic        parallel_if_enable,
    input wire logic        op_abort,
    input wire logic        mem_req_valid,
    input wire logic        mem_req_write,
    input wire logic [18:0] mem_req_addr
);
    import lpc_flash_pkg::*;
    wire logic prog;
    wire logic top_blk;
    wire logic in_rst;
    assign prog = mem_req_valid && mem_req_write;
    assign top_blk = mem_req_addr[BLOCK_MSB:BLOCK_LSB] == TOP_BLOCK;
    // In-system reset only counts while the strap selects the bus side
    assign in_rst = !rst_pin_n || (!init_pin_n && !parallel_programmer_mode);

    a_mode_select: assert property (@(posedge clock) disable iff (!resetn)
        !op_abort |-> lpc_if_enable == !parallel_programmer_mode
            && parallel_if_enable == parallel_programmer_mode)
        else $error("interface enable disagrees with mode strap");
    a_pin_reset: assert property (@(posedge clock) disable iff (!resetn)
        !rst_pin_n |-> op_abort)
        else $error("reset pin low without abort");
    a_init_reset: assert property (@(posedge clock) disable iff (!resetn)
        !init_pin_n && !parallel_programmer_mode |-> op_abort)
        else $error("second reset pin ignored in bus mode");
    a_abort_ends: assert property (@(posedge clock) disable iff (!resetn)
        (!in_rst) [*8] |-> !op_abort)
        else $error("abort held after reset release");
    a_reset_floats: assert property (@(posedge lclk) disable iff (!resetn)
        in_rst |-> !lad_oe)
        else $error("bus driven during reset");
    a_frame_abort: assert property (@(posedge lclk) disable iff (!resetn)
        lad_oe && !lframe_n |=> !lad_oe)
        else $error("bus kept after frame abort");
    a_top_lock: assert property (@(posedge clock) disable iff (!resetn)
        prog && top_blk |-> top_boot_lock_n)
        else $error("locked top block programmed");
    a_guard_low: assert property (@(posedge clock) disable iff (!resetn)
        prog && !top_blk |-> write_guard_n)
        else $error("guarded block programmed");
endmodule

// [sim/lpc_host_model.sv]
`timescale 1ns/1ps
module lpc_host_model
    import lpc_flash_pkg::*;
(
    input  wire logic       lclk,
    input  wire logic [3:0] lad_wire,
    input  wire logic       lad_oe,
    output logic            lframe_n,
    output logic      [3:0] host_lad,
    output logic            host_oe,
    output logic            res_strobe,
    output logic      [8:0] res_val
);
    initial
    begin
        lframe_n = 1'b1;
        host_lad = LAD_IDLE_LEVEL;
        host_oe = 1'b0;
        res_strobe = 1'b0;
        res_val = 9'h000;
    end

    // Falling-edge launch keeps every nibble stable at the sampling edge
    task automatic put(input logic fr, input logic [3:0] nib);
        @(negedge lclk);
        lframe_n = fr;
        host_lad = nib;
        host_oe = 1'b1;
    endtask

    task automatic frame(input logic [3:0] st, input logic [3:0] id,
                         input logic [27:0] a, input logic [7:0] wd,
                         input int ab);
        logic       ok;
        logic [7:0] rd;
        int         n;
        ok = 1'b0;
        rd = 8'h00;
        put(1'b0, st);
        put(1'b1, id);
        for (n = 6; n >= 0; n--)
            put(1'b1, a[n*4 +: 4]);
        put(1'b1, MSIZE_BYTE);
        if (st == START_FW_WRITE)
        begin
            put(1'b1, wd[3:0]);
            put(1'b1, wd[7:4]);
        end
        put(1'b1, LAD_IDLE_LEVEL);
        put(1'b1, LAD_IDLE_LEVEL);
        // Abort drives the strobe low for two cycles in mid-wait
        for (n = 0; n < 100 && !ok; n++)
        begin
            @(negedge lclk);
            lframe_n = (n != ab);
            host_oe = (n == ab);
            if (n == ab)
                n = 100;
            else
                ok = lad_oe && lad_wire == SYNC_READY;
        end
        if (ok && st == START_FW_READ)
        begin
            @(negedge lclk);
            rd[3:0] = lad_wire;
            @(negedge lclk);
            rd[7:4] = lad_wire;
        end
        repeat (2) @(negedge lclk);
        lframe_n = 1'b1;
        host_oe = 1'b0;
        res_val = {ok, rd};
        res_strobe = 1'b1;
        @(negedge lclk);
        res_strobe = 1'b0;
    endtask
endmodule

// [sim/lpc_flash_pin_control_tb.sv]
`timescale 1ns/1ps
module lpc_flash_pin_control_tb;
    import lpc_flash_pkg::*;
    localparam logic [3:0] RD = START_FW_READ;
    localparam logic [3:0] WR = START_FW_WRITE;
    logic        clock = 1'b0;
    logic        lclk = 1'b0;
    logic        resetn = 1'b0;
    logic        rst_pin_n = 1'b1;
    logic        init_pin_n = 1'b1;
    logic        parallel_programmer_mode = 1'b0;
    logic [3:0]  chip_select_strap = 4'h0;
    logic [4:0]  general_input_pins = 5'h00;
    logic        top_boot_lock_n = 1'b1;
    logic        write_guard_n = 1'b1;
    logic        mem_req_ready = 1'b0;
    logic        mem_rsp_valid = 1'b0;
    logic [7:0]  mem_rsp_data = 8'h00;
    logic        lframe_n, lad_oe, host_oe, lpc_if_enable, parallel_if_enable;
    logic        op_abort, mem_req_valid, mem_req_write, write_refused;
    logic        res_strobe, pw, ok_w;
    logic [3:0]  lad_in, lad_out, host_lad;
    logic [18:0] mem_req_addr, pa;
    logic [7:0]  mem_req_wdata, pd, wd;
    logic [8:0]  res_val, ex;
    logic [27:0] a;
    logic [31:0] rnd;
    logic [7:0]  mem [int];
    logic [8:0]  notes [$];
    int          seed = 95103;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          refused_exp = 0;
    int          refused_seen = 0;
    int          i;

    always #4 clock = ~clock;
    initial
    begin
        #3.3;
        forever #15 lclk = ~lclk;
    end
    // Released LAD floats high through the board pull-ups
    assign lad_in = lad_oe ? lad_out : (host_oe ? host_lad : LAD_IDLE_LEVEL);

    lpc_flash_pin_control u_lpc_flash_pin_control (
        .clock(clock), .resetn(resetn), .lclk(lclk),
        .rst_pin_n(rst_pin_n), .init_pin_n(init_pin_n),
        .parallel_programmer_mode(parallel_programmer_mode),
        .chip_select_strap(chip_select_strap),
        .general_input_pins(general_input_pins),
        .top_boot_lock_n(top_boot_lock_n), .write_guard_n(write_guard_n),
        .lframe_n(lframe_n), .lad_in(lad_in), .lad_out(lad_out),
        .lad_oe(lad_oe), .lpc_if_enable(lpc_if_enable),
        .parallel_if_enable(parallel_if_enable), .op_abort(op_abort),
        .mem_req_valid(mem_req_valid), .mem_req_write(mem_req_write),
        .mem_req_addr(mem_req_addr), .mem_req_wdata(mem_req_wdata),
        .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .write_refused(write_refused));
    lpc_host_model u_lpc_host_model (
        .lclk(lclk), .lad_wire(lad_in), .lad_oe(lad_oe),
        .lframe_n(lframe_n), .host_lad(host_lad), .host_oe(host_oe),
        .res_strobe(res_strobe), .res_val(res_val));

    // Array model with a random accept delay; unwritten bytes read erased
    always @(negedge clock)
    begin
        rnd = $random(seed);
        mem_rsp_valid <= 1'b0;
        if (mem_req_ready)
        begin
            mem_req_ready <= 1'b0;
            if (pw)
                mem[int'(pa)] = pd;
            else
                mem_rsp_valid <= 1'b1;
            mem_rsp_data <= mem.exists(int'(pa)) ? mem[int'(pa)] : 8'hFF;
        end
        else if (mem_req_valid && rnd[1:0] == 2'h0)
        begin
            mem_req_ready <= 1'b1;
            pw = mem_req_write;
            pa = mem_req_addr;
            pd = mem_req_wdata;
        end
    end

    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic xfer(input logic [3:0] st, input logic [3:0] id,
                        input logic [27:0] ax, input logic [7:0] wx,
                        input int ab, input logic [8:0] exp);
        notes.push_back(exp);
        u_lpc_host_model.frame(st, id, ax, wx, ab);
    endtask

    always @(posedge res_strobe)
        check("bus result", res_val, notes.pop_front());

    always @(posedge clock)
    begin
        cycles++;
        if (write_refused === 1'b1)
            refused_seen++;
        if (cycles == 60000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        repeat (12) @(negedge lclk);
        check("mode", {7'h00, parallel_if_enable, lpc_if_enable}, 9'h001);
        for (i = 0; i < 4; i++)
        begin
            @(negedge clock);
            general_input_pins = 5'($random(seed));
            ex = {4'h8, general_input_pins};
            repeat (4) @(negedge lclk);
            xfer(RD, 4'h0, GPI_REG_ADDR, 8'h00, -1, ex);
        end
        for (i = 0; i < 8; i++)
        begin
            @(negedge clock);
            top_boot_lock_n = i[0];
            write_guard_n = i[1];
            a = {9'h1FF, (i[2] ? TOP_BLOCK : 3'(i)), 16'h0123 * 16'(i)};
            wd = 8'($random(seed));
            ok_w = i[2] ? i[0] : i[1];
            refused_exp += int'(!ok_w);
            ex = {1'b1, ok_w ? wd : 8'hFF};
            xfer(WR, 4'h0, a, wd, -1, 9'h100);
            xfer(RD, 4'h0, a, 8'h00, -1, ex);
        end
        xfer(4'h0, 4'h0, GPI_REG_ADDR, 8'h00, -1, 9'h000);
        xfer(RD, 4'h3, GPI_REG_ADDR, 8'h00, -1, 9'h000);
        xfer(WR, 4'h9, a, 8'h5A, -1, 9'h000);
        xfer(RD, 4'h0, a, 8'h00, 1, 9'h000);
        xfer(RD, 4'h0, a, 8'h00, -1, ex);
        for (i = 0; i < 2; i++)
            fork
                xfer(i ? RD : WR, 4'h0, 28'hFF8_2222, 8'hC3, -1, 9'h000);
                begin
                    repeat (44) @(negedge clock);
                    rst_pin_n = 1'b0;
                    repeat (16) @(negedge clock);
                    check("abort", 9'(op_abort), 9'h001);
                    rst_pin_n = 1'b1;
                end
            join
        check("refused", 9'(refused_seen), 9'(refused_exp));
        init_pin_n = 1'b0;
        chip_select_strap = 4'h5;
        repeat (16) @(negedge clock);
        check("init reset", 9'(op_abort), 9'h001);
        init_pin_n = 1'b1;
        repeat (12) @(negedge lclk);
        ex = {4'h8, general_input_pins};
        xfer(RD, 4'h5, GPI_REG_ADDR, 8'h00, -1, ex);
        xfer(RD, 4'h0, GPI_REG_ADDR, 8'h00, -1, 9'h000);
        @(negedge clock);
        resetn = 1'b0;
        parallel_programmer_mode = 1'b1;
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        repeat (12) @(negedge lclk);
        check("pp", {7'h00, parallel_if_enable, lpc_if_enable}, 9'h002);
        init_pin_n = 1'b0;
        repeat (8) @(negedge clock);
        check("pp init", 9'(op_abort), 9'h000);
        init_pin_n = 1'b1;
        xfer(RD, 4'h5, GPI_REG_ADDR, 8'h00, -1, 9'h000);
        print_verdict();
    end
endmodule

bind lpc_flash_pin_control lpc_flash_pin_control_sva u_lpc_flash_pin_control_sva (
    .clock(clock), .resetn(resetn), .lclk(lclk), .rst_pin_n(rst_pin_n),
    .init_pin_n(init_pin_n),
    .parallel_programmer_mode(parallel_programmer_mode),
    .top_boot_lock_n(top_boot_lock_n), .write_guard_n(write_guard_n),
    .lframe_n(lframe_n), .lad_oe(lad_oe), .lpc_if_enable(lpc_if_enable),
    .parallel_if_enable(parallel_if_enable), .op_abort(op_abort),
    .mem_req_valid(mem_req_valid), .mem_req_write(mem_req_write),
    .mem_req_addr(mem_req_addr));
